// ---- src/dwp_fifo.sv ----
// sample fifo with valid/ready on both sides, storage in flip-flops
`timescale 1ns/1ps
`default_nettype none
module dwp_fifo import dwp_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2047,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [CW-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("dwp_fifo: depth below 2 or width below 1");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    // a full fifo still takes a word in the cycle it hands one out
    assign o_out_valid = cnt_q != '0;
    assign o_in_ready = (cnt_q != CW'(DEPTH)) || i_out_ready;
    assign o_out_data = mem_q[rd_q];
    assign o_count = cnt_q;
    wire logic push = i_in_valid && o_in_ready;
    wire logic pop = o_out_valid && i_out_ready;
    wire logic [AW-1:0] wr_nx = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    wire logic [AW-1:0] rd_nx = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (i_clear) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? wr_nx : wr_q;
            rd_q <= pop ? rd_nx : rd_q;
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_fifo_depth_bound: assert property (cnt_q <= CW'(DEPTH))
        else $error("fifo count above depth");
    chk_fifo_full_refuse: assert property ((cnt_q == CW'(DEPTH)) && !i_out_ready && !i_clear |=> $stable(cnt_q))
        else $error("full fifo took a word");
endmodule
`default_nettype wire

// ---- src/dwp_pkg.sv ----
// types shared by the digital line port
package dwp_pkg;
    typedef enum logic [1:0] {
        DWP_PFI_STATIC_IN = 2'h0,
        DWP_PFI_STATIC_OUT = 2'h1,
        DWP_PFI_TIMING_IN = 2'h2,
        DWP_PFI_TIMING_OUT = 2'h3
    } dwp_pfi_mode_t;
    typedef enum logic [1:0] {
        DWP_FLT_OFF = 2'h0,
        DWP_FLT_SHORT = 2'h1,
        DWP_FLT_MID = 2'h2,
        DWP_FLT_LONG = 2'h3
    } dwp_flt_sel_t;
endpackage

// ---- src/dwp_regs.svh ----
// register offsets, field positions, reset values and timing counts of the digital line port
`ifndef DWP_REGS_SVH
`define DWP_REGS_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define DWP_REG_CTRL 8'h00
`define DWP_REG_CLKSEL 8'h04
`define DWP_REG_P0_DIR 8'h08
`define DWP_REG_P0_OUT 8'h0c
`define DWP_REG_P0_IN 8'h10
`define DWP_REG_PFI_MODE 8'h14
`define DWP_REG_PFI_FLT 8'h18
`define DWP_REG_PFI_OUT 8'h1c
`define DWP_REG_PFI_IN 8'h20
`define DWP_REG_TOSEL_LO 8'h24
`define DWP_REG_TOSEL_HI 8'h28
`define DWP_REG_GEN_DATA 8'h2c
`define DWP_REG_ACQ_DATA 8'h30
`define DWP_REG_STATUS 8'h34
// ************************************************************
// field positions
// ************************************************************
`define DWP_CTRL_GEN_EN 0
`define DWP_CTRL_ACQ_EN 1
`define DWP_CTRL_REGEN 2
`define DWP_CTRL_GEN_CLR 3
`define DWP_CTRL_ACQ_CLR 4
`define DWP_CTRL_DMA_EN 5
`define DWP_CLKSEL_FALL 8
`define DWP_ST_GEN_CNT 0
`define DWP_ST_UNDER 12
`define DWP_ST_ACQ_CNT 16
`define DWP_ST_OVER 28
// ************************************************************
// reset values
// ************************************************************
`define DWP_RST_CTRL 6'h00
`define DWP_RST_CLKSEL 5'h00
`define DWP_RST_DIR 8'h00
`define DWP_RST_MODE 32'h0000_0000
`define DWP_RST_FLT 32'h0000_0000
// ************************************************************
// timing
// ************************************************************
`define DWP_CLK_NS 25
`define DWP_FLT_SHORT_NS 125
`define DWP_FLT_MID_PS 6425000
`define DWP_FLT_LONG_NS 2560000
`define DWP_FLT_SHORT_CYC ((`DWP_FLT_SHORT_NS + `DWP_CLK_NS - 1) / `DWP_CLK_NS)
`define DWP_FLT_MID_CYC ((`DWP_FLT_MID_PS + `DWP_CLK_NS * 1000 - 1) / (`DWP_CLK_NS * 1000))
`define DWP_FLT_LONG_CYC ((`DWP_FLT_LONG_NS + `DWP_CLK_NS - 1) / `DWP_CLK_NS)
`define DWP_FIFO_DEPTH 2047
`endif

// ---- src/dwp_top.sv ----
// digital line port: static lines, clocked waveform path, programmable function lines
`timescale 1ns/1ps
`default_nettype none
`include "dwp_regs.svh"
// Overview of operation
// - 24 lines: eight port-zero lines and sixteen programmable function lines.
// - every line has its own input or output direction set by software.
// - only port-zero lines run clocked waveforms, up to eight bits per edge.
// - outgoing waveform samples pass a 2047-sample fifo.
// - incoming waveform samples pass a 2047-sample fifo.
// - no own sample timer; the sample clock always comes from outside.
// - sample clock selectable from function lines, trigger bus, analog and counter clocks.
// - acquisition accepts sample clocks up to 10 MHz.
// - generation regenerates from the fifo or streams from host memory.
// - function lines work as static in, static out, timing in, timing out.
// - a timing output line drives one of many internal timing signals.
// - per-line debounce of 125 ns, 6.425 us, 2.56 ms or off, both edges.
// - waveform data moves by dma request or programmed register access.
module dwp_top import dwp_pkg::*; #(
    parameter int P0_W = 8,
    parameter int PFI_N = 16,
    parameter int FIFO_DEPTH = `DWP_FIFO_DEPTH,
    parameter int FLT_LONG_CYC = `DWP_FLT_LONG_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [P0_W-1:0] i_p0_in,
    output logic [P0_W-1:0] o_p0_out,
    output logic [P0_W-1:0] o_p0_oe,
    input wire logic [PFI_N-1:0] i_pfi_in,
    output logic [PFI_N-1:0] o_pfi_out,
    output logic [PFI_N-1:0] o_pfi_oe,
    output logic [PFI_N-1:0] o_pfi_timing_in,
    input wire logic [7:0] i_trig_bus,
    input wire logic i_ai_sample_clk,
    input wire logic i_ai_convert_clk,
    input wire logic i_ao_sample_clk,
    input wire logic [1:0] i_ctr_out,
    input wire logic [2:0] i_int_sig,
    input wire logic [15:0] i_timing_sig,
    output logic o_gen_dma_req,
    output logic o_acq_dma_req
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int FW = 17;
    // fixed widths
    if (P0_W != 8 || PFI_N != 16 || FLT_LONG_CYC < 1 || FLT_LONG_CYC >= (1 << FW) || CW > 12) begin : g_bad
        $error("dwp_top: unsupported line count, filter count or fifo depth");
    end
    function automatic logic [FW-1:0] flt_limit(input logic [1:0] sel);
        unique case (dwp_flt_sel_t'(sel))
            DWP_FLT_SHORT: flt_limit = FW'(`DWP_FLT_SHORT_CYC);
            DWP_FLT_MID: flt_limit = FW'(`DWP_FLT_MID_CYC);
            DWP_FLT_LONG: flt_limit = FW'(FLT_LONG_CYC);
            DWP_FLT_OFF: flt_limit = '0;
        endcase
    endfunction
    // ************************************************************
    // apb decode
    // ************************************************************
    wire logic setup = i_psel && !i_penable;
    wire logic access = i_psel && i_penable;
    wire logic wr = access && i_pwrite;
    wire logic rd = access && !i_pwrite;
    wire logic a_ctrl = i_paddr == `DWP_REG_CTRL;
    wire logic a_clk = i_paddr == `DWP_REG_CLKSEL;
    wire logic a_p0dir = i_paddr == `DWP_REG_P0_DIR;
    wire logic a_p0out = i_paddr == `DWP_REG_P0_OUT;
    wire logic a_p0in = i_paddr == `DWP_REG_P0_IN;
    wire logic a_mode = i_paddr == `DWP_REG_PFI_MODE;
    wire logic a_flt = i_paddr == `DWP_REG_PFI_FLT;
    wire logic a_pfiout = i_paddr == `DWP_REG_PFI_OUT;
    wire logic a_pfiin = i_paddr == `DWP_REG_PFI_IN;
    wire logic a_tolo = i_paddr == `DWP_REG_TOSEL_LO;
    wire logic a_tohi = i_paddr == `DWP_REG_TOSEL_HI;
    wire logic a_gdata = i_paddr == `DWP_REG_GEN_DATA;
    wire logic a_adata = i_paddr == `DWP_REG_ACQ_DATA;
    wire logic a_stat = i_paddr == `DWP_REG_STATUS;
    wire logic mapped = a_ctrl | a_clk | a_p0dir | a_p0out | a_p0in | a_mode | a_flt | a_pfiout | a_pfiin
        | a_tolo | a_tohi | a_gdata | a_adata | a_stat;
    logic [5:0] ctrl_q;
    logic [8:0] clksel_q;
    logic [7:0] p0_dir_q;
    logic [7:0] p0_out_q;
    logic [31:0] mode_q;
    logic [31:0] flt_q;
    logic [15:0] pfi_out_q;
    logic [63:0] tosel_q;
    logic [31:0] prdata_q;
    logic st_under_q;
    logic st_over_q;
    wire logic gen_en = ctrl_q[`DWP_CTRL_GEN_EN];
    wire logic acq_en = ctrl_q[`DWP_CTRL_ACQ_EN];
    wire logic regen = ctrl_q[`DWP_CTRL_REGEN];
    wire logic dma_en = ctrl_q[`DWP_CTRL_DMA_EN];
    wire logic gen_clr = wr && a_ctrl && i_pwdata[`DWP_CTRL_GEN_CLR];
    wire logic acq_clr = wr && a_ctrl && i_pwdata[`DWP_CTRL_ACQ_CLR];
    logic gen_in_ready;
    logic gen_valid;
    logic [7:0] gen_head;
    logic [CW-1:0] gen_count;
    logic acq_in_ready;
    logic acq_valid;
    logic [7:0] acq_head;
    logic [CW-1:0] acq_count;
    // in regeneration the fifo feeds itself, so software pushes are refused
    wire logic push_bad = wr && a_gdata && (regen || !gen_in_ready);
    wire logic pop_bad = rd && a_adata && !acq_valid;
    wire logic apb_push = wr && a_gdata && !push_bad;
    wire logic acq_pop = rd && a_adata && acq_valid;
    assign o_pready = 1'b1;
    assign o_pslverr = access && (!mapped || push_bad || pop_bad);
    assign o_prdata = prdata_q;
    // ************************************************************
    // input synchronisers and debounce filters
    // ************************************************************
    logic [7:0] p0_s1_q;
    logic [7:0] p0_s2_q;
    logic [7:0] tb_s1_q;
    logic [7:0] tb_s2_q;
    logic [PFI_N-1:0] pfi_filt;
    logic [PFI_N-1:0] pfi_sync;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            p0_s1_q <= '0;
            p0_s2_q <= '0;
            tb_s1_q <= '0;
            tb_s2_q <= '0;
        end else begin
            p0_s1_q <= i_p0_in;
            p0_s2_q <= p0_s1_q;
            tb_s1_q <= i_trig_bus;
            tb_s2_q <= tb_s1_q;
        end
    end
    for (genvar g = 0; g < PFI_N; g++) begin : g_flt
        logic s1_q;
        logic s2_q;
        logic f_q;
        logic [FW-1:0] c_q;
        wire logic [FW-1:0] lim = flt_limit(flt_q[2*g +: 2]);
        wire logic differ = s2_q != f_q;
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                f_q <= 1'b0;
                c_q <= '0;
            end else begin
                s1_q <= i_pfi_in[g];
                s2_q <= s1_q;
                // a change must persist for the whole window, in either direction
                f_q <= (lim == '0 || (differ && c_q + 1'b1 == lim)) ? s2_q : f_q;
                c_q <= (!differ || lim == '0 || c_q + 1'b1 == lim) ? '0 : c_q + 1'b1;
            end
        end
        assign pfi_filt[g] = f_q;
        assign pfi_sync[g] = s2_q;
        // timing input lines are handed on to the other subsystems
        assign o_pfi_timing_in[g] = f_q && (mode_q[2*g +: 2] == DWP_PFI_TIMING_IN);
    end
    // ************************************************************
    // sample clock selection
    // ************************************************************
    // there is no sample timer here; every source is someone else's clock
    wire logic [31:0] src_vec = {i_int_sig, i_ctr_out, i_ao_sample_clk, i_ai_convert_clk, i_ai_sample_clk,
        tb_s2_q, pfi_filt};
    wire logic src_sel = src_vec[clksel_q[4:0]] ^ clksel_q[`DWP_CLKSEL_FALL];
    logic src_q;
    // at 40 MHz a 10 MHz clock still gives one edge per four cycles
    wire logic samp_edge = src_sel && !src_q;
    wire logic gen_pop = gen_en && samp_edge && gen_valid;
    wire logic acq_push = acq_en && samp_edge;
    // ************************************************************
    // waveform fifos
    // ************************************************************
    dwp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_gen_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clear(gen_clr),
        .i_in_valid(regen ? gen_pop : apb_push),
        .o_in_ready(gen_in_ready),
        .i_in_data(regen ? gen_head : i_pwdata[7:0]),
        .o_out_valid(gen_valid),
        .i_out_ready(gen_pop),
        .o_out_data(gen_head),
        .o_count(gen_count)
    );
    dwp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_acq_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clear(acq_clr),
        .i_in_valid(acq_push),
        .o_in_ready(acq_in_ready),
        .i_in_data(p0_s2_q),
        .o_out_valid(acq_valid),
        .i_out_ready(acq_pop),
        .o_out_data(acq_head),
        .o_count(acq_count)
    );
    // streaming fills from host memory; regeneration needs no requests
    assign o_gen_dma_req = dma_en && !regen && (gen_count != CW'(FIFO_DEPTH));
    assign o_acq_dma_req = dma_en && acq_valid;
    // ************************************************************
    // readback
    // ************************************************************
    wire logic [31:0] st_val = (32'(gen_count) << `DWP_ST_GEN_CNT) | (32'(st_under_q) << `DWP_ST_UNDER)
        | (32'(acq_count) << `DWP_ST_ACQ_CNT) | (32'(st_over_q) << `DWP_ST_OVER);
    wire logic [31:0] rd_val = ({32{a_ctrl}} & 32'(ctrl_q)) | ({32{a_clk}} & 32'(clksel_q))
        | ({32{a_p0dir}} & 32'(p0_dir_q)) | ({32{a_p0out}} & 32'(p0_out_q)) | ({32{a_p0in}} & 32'(p0_s2_q))
        | ({32{a_mode}} & mode_q) | ({32{a_flt}} & flt_q) | ({32{a_pfiout}} & 32'(pfi_out_q))
        | ({32{a_pfiin}} & 32'(pfi_filt)) | ({32{a_tolo}} & tosel_q[31:0]) | ({32{a_tohi}} & tosel_q[63:32])
        | ({32{a_adata}} & 32'(acq_head)) | ({32{a_stat}} & st_val);
    wire logic under_set = gen_en && samp_edge && !gen_valid;
    wire logic over_set = acq_push && !acq_in_ready;
    wire logic st_wr = wr && a_stat;
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] gen_samp_q;
    logic [7:0] p0_drv_q;
    logic [15:0] pfi_drv_q;
    logic [15:0] pfi_drv_d;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= `DWP_RST_CTRL;
            clksel_q <= {1'b0, 3'h0, `DWP_RST_CLKSEL};
            p0_dir_q <= `DWP_RST_DIR;
            p0_out_q <= 8'h00;
            mode_q <= `DWP_RST_MODE;
            flt_q <= `DWP_RST_FLT;
            pfi_out_q <= 16'h0000;
            tosel_q <= 64'h0;
            prdata_q <= 32'h0;
        end else begin
            // clear bits are pulses and never stored
            if (wr && a_ctrl) ctrl_q <= i_pwdata[5:0] & ~6'h18;
            if (wr && a_clk) clksel_q <= i_pwdata[8:0];
            if (wr && a_p0dir) p0_dir_q <= i_pwdata[7:0];
            if (wr && a_p0out) p0_out_q <= i_pwdata[7:0];
            if (wr && a_mode) mode_q <= i_pwdata;
            if (wr && a_flt) flt_q <= i_pwdata;
            if (wr && a_pfiout) pfi_out_q <= i_pwdata[15:0];
            if (wr && a_tolo) tosel_q[31:0] <= i_pwdata;
            if (wr && a_tohi) tosel_q[63:32] <= i_pwdata;
            if (setup) prdata_q <= rd_val;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_q <= 1'b0;
            gen_samp_q <= 8'h00;
            p0_drv_q <= 8'h00;
            pfi_drv_q <= 16'h0000;
            st_under_q <= 1'b0;
            st_over_q <= 1'b0;
        end else begin
            src_q <= src_sel;
            if (gen_pop) gen_samp_q <= gen_head;
            p0_drv_q <= gen_en ? gen_samp_q : p0_out_q;
            pfi_drv_q <= pfi_drv_d;
            // a new event beats a write-one clear in the same cycle
            st_under_q <= under_set || (st_under_q && !(st_wr && i_pwdata[`DWP_ST_UNDER]));
            st_over_q <= over_set || (st_over_q && !(st_wr && i_pwdata[`DWP_ST_OVER]));
        end
    end
    // ************************************************************
    // pin drivers
    // ************************************************************
    for (genvar g = 0; g < PFI_N; g++) begin : g_pfi_drv
        wire logic [1:0] m = mode_q[2*g +: 2];
        assign pfi_drv_d[g] = (m == DWP_PFI_TIMING_OUT) ? i_timing_sig[tosel_q[4*g +: 4]]
            : (m == DWP_PFI_STATIC_OUT) && pfi_out_q[g];
        assign o_pfi_oe[g] = m[0];
    end
    assign o_pfi_out = pfi_drv_q;
    assign o_p0_out = p0_drv_q;
    assign o_p0_oe = p0_dir_q;
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_flt_short_run;
        !g_flt[1].differ ##1 (g_flt[1].differ && flt_q[3:2] == DWP_FLT_SHORT)[*5];
    endsequence
    sequence s_gen_step;
        gen_pop ##1 gen_en;
    endsequence
    chk_dir_to_oe: assert property (wr && a_p0dir |=> o_p0_oe == $past(i_pwdata[7:0]))
        else $error("port-zero enable did not follow direction write");
    chk_pfi_oe_mode: assert property (wr && a_mode |=> o_pfi_oe[3] == $past(i_pwdata[6]))
        else $error("function line enable not taken from its mode");
    chk_acq_count_up: assert property (acq_push && acq_in_ready && !acq_pop && !acq_clr
        |=> acq_count == $past(acq_count) + 1'b1)
        else $error("acquired sample not stored");
    chk_acq_overflow: assert property (over_set |=> st_over_q)
        else $error("overflow not flagged");
    chk_gen_drive: assert property (s_gen_step |=> o_p0_out == $past(gen_head, 2))
        else $error("generated sample not driven");
    chk_regen_hold: assert property (regen && gen_pop && !gen_clr |=> gen_count == $past(gen_count))
        else $error("regeneration lost a sample");
    chk_flt_off_pass: assert property (flt_q[1:0] == DWP_FLT_OFF && $stable(flt_q[1:0])
        |=> pfi_filt[0] == $past(pfi_sync[0]))
        else $error("disabled filter did not pass the line");
    chk_flt_short_win: assert property (s_flt_short_run |=> pfi_filt[1] == $past(pfi_sync[1]))
        else $error("short filter window wrong");
    chk_pio_pop: assert property (acq_pop && !acq_push && !acq_clr |=> acq_count == $past(acq_count) - 1'b1)
        else $error("register read did not drain the fifo");
    chk_clk_edge: assert property (samp_edge |-> !$past(src_sel))
        else $error("sample edge without a rising source");
endmodule
`default_nettype wire

// ---- testbench/dwp_field_model.sv ----
// field wiring model for the port-zero and function lines
`timescale 1ns/1ps
`default_nettype none
module dwp_field_model (
    input wire logic [7:0] i_p0_out,
    input wire logic [7:0] i_p0_oe,
    input wire logic [7:0] i_p0_drv,
    input wire logic [15:0] i_pfi_out,
    input wire logic [15:0] i_pfi_oe,
    input wire logic [15:0] i_pfi_drv,
    output logic [7:0] o_p0_pin,
    output logic [15:0] o_pfi_pin
);
    // a line the device drives shows its level, else the field source wins
    assign o_p0_pin = (i_p0_oe & i_p0_out) | (~i_p0_oe & i_p0_drv);
    assign o_pfi_pin = (i_pfi_oe & i_pfi_out) | (~i_pfi_oe & i_pfi_drv);
endmodule
`default_nettype wire

// ---- testbench/dwp_top_tb.sv ----
// self-checking bench of the digital line port
`timescale 1ns/1ps
`default_nettype none
`include "dwp_regs.svh"
module dwp_top_tb;
    logic i_clk, i_rst_n, psel, pen, pwr, pready, pslverr, rd_err, gen_req, acq_req;
    logic [7:0] paddr, p0_out, p0_oe, p0_pin, p0_drv;
    logic [31:0] pwdata, prdata, rd_data, seed, r;
    logic [15:0] pfi_out, pfi_oe, pfi_pin, pfi_drv, pfi_tin, misc, tsig;
    logic [7:0] sv [8];
    int fails, checked, n;
    dwp_top #(.FIFO_DEPTH(16), .FLT_LONG_CYC(20)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_p0_in(p0_pin), .o_p0_out(p0_out), .o_p0_oe(p0_oe), .i_pfi_in(pfi_pin),
        .o_pfi_out(pfi_out), .o_pfi_oe(pfi_oe), .o_pfi_timing_in(pfi_tin), .i_trig_bus(misc[7:0]),
        .i_ai_sample_clk(misc[8]), .i_ai_convert_clk(misc[9]), .i_ao_sample_clk(misc[10]),
        .i_ctr_out(misc[12:11]), .i_int_sig(misc[15:13]), .i_timing_sig(tsig), .o_gen_dma_req(gen_req),
        .o_acq_dma_req(acq_req));
    dwp_field_model u_field (.i_p0_out(p0_out), .i_p0_oe(p0_oe), .i_p0_drv(p0_drv), .i_pfi_out(pfi_out),
        .i_pfi_oe(pfi_oe), .i_pfi_drv(pfi_drv), .o_p0_pin(p0_pin), .o_pfi_pin(pfi_pin));
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] mode_oe(input logic [31:0] m);
        for (int i = 0; i < 16; i++) mode_oe[i] = m[2*i];
    endfunction
    task automatic tick(input int c);
        repeat (c) @(posedge i_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // one sample edge on function line 0; long enough to clear sync and edge lag
    task automatic edge_pulse();
        pfi_drv[0] <= 1'b0;
        tick(4);
        pfi_drv[0] <= 1'b1;
        tick(10);
    endtask
    task automatic print_verdict();
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) misc <= rnd();
    initial begin
        #(25 * 60000);
        fails++;
        print_verdict();
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        seed = 32'hfa548170; fails = 0; checked = 0; i_rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; p0_drv = 8'h00; pfi_drv = 16'h0; tsig = 16'h0; misc = 16'h0;
        tick(4);
        i_rst_n <= 1'b1;
        foreach (sv[i]) begin
            rd(i * 4); if (i == 5) rd(`DWP_REG_PFI_FLT);
            chk("reset_value", 32'h0, rd_data);
        end
        chk("reset_oe", 32'h0, {p0_oe, pfi_oe});
        chk("pready", 32'h1, pready);
        rd(8'hfc); chk("unmapped_err", 32'h1, rd_err);
        for (int k = 0; k < 4; k++) begin
            r = rnd(); wr(`DWP_REG_P0_DIR, r[7:0]); wr(`DWP_REG_P0_OUT, r[15:8]); p0_drv <= r[23:16]; tick(4);
            chk("p0_oe", r[7:0], p0_oe);
            chk("p0_out", r[15:8] & r[7:0], p0_out & p0_oe);
            rd(`DWP_REG_P0_IN); chk("p0_in", (r[15:8] & r[7:0]) | (r[23:16] & ~r[7:0]), rd_data);
        end
        for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? 32'he4e4e4e4 : rnd(); wr(`DWP_REG_PFI_MODE, r); tick(2);
            chk("pfi_oe", mode_oe(r), pfi_oe);
        end
        wr(`DWP_REG_PFI_MODE, 32'h0);
        for (int s = 1; s < 4; s++) begin
            n = (s == 1) ? 5 : (s == 2) ? 257 : 20;
            wr(`DWP_REG_PFI_FLT, s << 2); pfi_drv[1] <= 1'b1; tick(n - 2); pfi_drv[1] <= 1'b0; tick(n + 8);
            rd(`DWP_REG_PFI_IN); chk("flt_glitch", 32'h0, rd_data);
            pfi_drv[1] <= 1'b1; tick(n + 8); rd(`DWP_REG_PFI_IN); chk("flt_rise", 32'h2, rd_data);
            pfi_drv[1] <= 1'b0; tick(n + 8); rd(`DWP_REG_PFI_IN); chk("flt_fall", 32'h0, rd_data);
        end
        wr(`DWP_REG_PFI_FLT, 32'h0); wr(`DWP_REG_CTRL, 32'h28); tick(2);
        chk("gen_req", 32'h1, gen_req);
        for (int i = 0; i < 16; i++) wr(`DWP_REG_GEN_DATA, rnd());
        wr(`DWP_REG_GEN_DATA, 32'h0); chk("gen_full", 32'h1, rd_err);
        chk("req_full", 32'h0, {gen_req, acq_req});
        rd(`DWP_REG_STATUS); chk("gen_count", 32'h10, rd_data[10:0]);
        wr(`DWP_REG_CTRL, 32'h8); foreach (sv[i]) begin sv[i] = rnd(); wr(`DWP_REG_GEN_DATA, sv[i]); end
        wr(`DWP_REG_P0_DIR, 8'hff); wr(`DWP_REG_CTRL, 32'h1);
        foreach (sv[i]) begin edge_pulse(); chk("gen_sample", sv[i], p0_out); end
        edge_pulse(); rd(`DWP_REG_STATUS); chk("underflow", 32'h1, rd_data[12]);
        wr(`DWP_REG_STATUS, 32'h1000); rd(`DWP_REG_STATUS); chk("under_clr", 32'h0, rd_data[12]);
        wr(`DWP_REG_CTRL, 32'h8); wr(`DWP_REG_GEN_DATA, sv[0]); wr(`DWP_REG_GEN_DATA, sv[1]);
        wr(`DWP_REG_CTRL, 32'h5);
        for (int i = 0; i < 4; i++) begin edge_pulse(); chk("regen", sv[i % 2], p0_out); end
        wr(`DWP_REG_GEN_DATA, 32'h0); chk("regen_push", 32'h1, rd_err);
        wr(`DWP_REG_P0_DIR, 8'h00); wr(`DWP_REG_CTRL, 32'h12);
        foreach (sv[i]) begin sv[i] = rnd(); p0_drv <= sv[i]; edge_pulse(); end
        wr(`DWP_REG_CTRL, 32'h20); tick(2); chk("acq_req", 32'h1, acq_req);
        foreach (sv[i]) begin rd(`DWP_REG_ACQ_DATA); chk("acq_sample", sv[i], rd_data); end
        rd(`DWP_REG_ACQ_DATA); chk("acq_empty", 32'h1, rd_err);
        wr(`DWP_REG_CTRL, 32'h2);
        repeat (17) edge_pulse();
        rd(`DWP_REG_STATUS); chk("overflow", 32'h1, rd_data[28]);
        chk("acq_full", 32'h10, rd_data[26:16]);
        wr(`DWP_REG_PFI_MODE, 32'h32); r = rnd(); wr(`DWP_REG_TOSEL_LO, {20'h0, r[3:0], 8'h0});
        for (int i = 0; i < 8; i++) begin
            tsig <= rnd(); tick(3);
            chk("timing_out", {1'b1, tsig[r[3:0]]}, {pfi_oe[2], pfi_out[2]});
            chk("timing_in", 32'h1, pfi_tin);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
